// ==== rtl/serial_flash_status_protect.sv ====
// serial flash identification, status byte and write protection logic
`timescale 1ns/1ps
// Overview of operation
// - identification returns three bytes on falling edges
// - identification ignored while a cycle runs
// - select high ends readout, back to standby
// - status readable always, repeated while clocked
// - busy flag high during any timed cycle
// - latch flag clear refuses all writes
// - protect bits guard area against program, erase
// - whole array clear only with protect zero
// - lock plus low pin rejects status write
// - status write needs latch set by unlock
// - bits 6,5,1,0 not written; 6,5 zero
// - select must rise at byte end, else discard
// - select rise starts timed cycle, then latch clears
// - lock clear lets status write with latch
// - lock set, pin high still writable
// - hardware mode keeps protected area fully locked
// - hardware mode entered in either order
// - only raising the pin or reset (lock bit cleared) leaves hardware mode
// - all bytes travel most significant bit first
// - input sampled on each rising clock edge
// - unlock sets latch, lock command clears it
module serial_flash_status_protect
    import flash_status_pkg::*;
#(
    parameter int STATUS_CYCLES = STATUS_WRITE_CYCLES,
    parameter int PAGE_CYCLES   = PAGE_WRITE_CYCLES,
    parameter int ZONE_CYCLES   = ZONE_CLEAR_CYCLES,
    parameter int ARRAY_CYCLES  = ARRAY_CLEAR_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        select_n,
    input  wire logic        serial_clock,
    input  wire logic        serial_in,
    input  wire logic        write_protect_n,
    output logic             serial_out,
    output logic             serial_out_oe,
    output logic             busy_flag,
    output logic             write_latch_flag,
    output logic             hard_protect_mode,
    output logic [7:0]       status_byte,
    output logic             array_op_start,
    output array_op_t        array_op_kind,
    output logic [23:0]      array_op_addr
);
    // ----------------------------------------------------------------
    // pin synchronisation and edge detection
    // ----------------------------------------------------------------
    logic        sel_n_s;
    logic        sclk_s;
    logic        sdi_s;
    logic        wp_n_s;
    logic        sclk_prev;
    logic        sel_n_prev;
    logic        selected;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        sel_end;

    pin_sync #(.WIDTH(4)) u_sync (
        .clock   (clock),
        .rst     (rst),
        .pin_in  ({select_n, serial_clock, serial_in, write_protect_n}),
        .pin_out ({sel_n_s, sclk_s, sdi_s, wp_n_s})
    );

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sclk_prev  <= 1'b0;
            sel_n_prev <= 1'b1;
        end
        else
        begin
            sclk_prev  <= sclk_s;
            sel_n_prev <= sel_n_s;
        end
    end

    assign selected  = ~sel_n_s;
    assign sclk_rise = selected & sclk_s & ~sclk_prev;
    assign sclk_fall = selected & ~sclk_s & sclk_prev;
    assign sel_end   = sel_n_s & ~sel_n_prev;

    // ----------------------------------------------------------------
    // status and protection state
    // ----------------------------------------------------------------
    logic        status_lock_bit;
    logic [2:0]  protect_level;
    logic [3:0]  staged_nv;
    logic        cycle_is_status;
    logic        timer_load;
    logic [31:0] timer_value;
    logic        timer_done;
    logic        latch_ok;

    assign hard_protect_mode = status_lock_bit & ~wp_n_s;
    assign status_byte       = {status_lock_bit, 2'b00, protect_level,
                                write_latch_flag, busy_flag};
    assign latch_ok          = write_latch_flag;

    // ----------------------------------------------------------------
    // serial command decode
    // ----------------------------------------------------------------
    link_state_t state;
    pending_t    pending;
    logic [2:0]  bit_cnt;
    logic [1:0]  byte_cnt;
    logic [7:0]  shift_in;
    logic [7:0]  next_byte;
    logic [7:0]  status_data;
    logic [23:0] addr;

    assign next_byte = {shift_in[6:0], sdi_s};

    always_ff @(posedge clock)
    begin
        if (rst || !selected)
        begin
            state    <= ST_CMD;
            bit_cnt  <= 3'h0;
            byte_cnt <= 2'h0;
            shift_in <= 8'h00;
            if (rst)
            begin
                pending     <= PEND_NONE;
                status_data <= 8'h00;
                addr        <= 24'h0;
            end
        end
        else if (sclk_rise)
        begin
            bit_cnt  <= bit_cnt + 3'h1;
            shift_in <= next_byte;
            if (state == ST_WAIT_END)
            begin
                state <= ST_IGNORE;
            end
            else if (bit_cnt == 3'h7)
            begin
                case (state)
                    ST_CMD:
                    begin
                        pending <= PEND_NONE;
                        case (next_byte)
                            READ_STATUS_CMD:  state <= ST_STATUS_OUT;
                            READ_IDENT_CMD:   state <= busy_flag ? ST_IGNORE : ST_ID_OUT;
                            WRITE_UNLOCK_CMD:
                            begin
                                state   <= busy_flag ? ST_IGNORE : ST_WAIT_END;
                                pending <= PEND_UNLOCK;
                            end
                            WRITE_LOCK_CMD:
                            begin
                                state   <= busy_flag ? ST_IGNORE : ST_WAIT_END;
                                pending <= PEND_LOCK;
                            end
                            WRITE_STATUS_CMD: state <= busy_flag ? ST_IGNORE : ST_STATUS_DATA;
                            PAGE_WRITE_CMD:
                            begin
                                state   <= busy_flag ? ST_IGNORE : ST_ADDR;
                                pending <= PEND_PAGE;
                            end
                            ZONE_CLEAR_CMD:
                            begin
                                state   <= busy_flag ? ST_IGNORE : ST_ADDR;
                                pending <= PEND_ZONE;
                            end
                            WHOLE_ARRAY_CLEAR_CMD:
                            begin
                                state   <= busy_flag ? ST_IGNORE : ST_WAIT_END;
                                pending <= PEND_ARRAY;
                            end
                            default:          state <= ST_IGNORE;
                        endcase
                    end
                    ST_STATUS_DATA:
                    begin
                        status_data <= next_byte;
                        pending     <= PEND_STATUS;
                        state       <= ST_WAIT_END;
                    end
                    ST_ADDR:
                    begin
                        addr     <= {addr[15:0], next_byte};
                        byte_cnt <= byte_cnt + 2'h1;
                        if (byte_cnt == 2'h2)
                        begin
                            byte_cnt <= 2'h0;
                            state    <= (pending == PEND_ZONE) ? ST_WAIT_END : ST_PAGE_DATA;
                        end
                    end
                    ST_PAGE_DATA:     byte_cnt <= 2'h1;
                    default:          state <= state;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // command commit when select rises
    // ----------------------------------------------------------------
    logic        commit;
    logic        start_status;
    logic        start_page;
    logic        start_zone;
    logic        start_array;
    logic        addr_protected;
    logic [6:0]  guarded_sectors;

    assign guarded_sectors = (protect_level == 3'h0) ? 7'h00
                           : 7'(SECTOR_COUNT >> (3'h7 - protect_level));
    assign addr_protected  = {1'b0, addr[21:16]} >= (7'(SECTOR_COUNT) - guarded_sectors);

    assign commit       = sel_end && ((state == ST_WAIT_END)
                        || (state == ST_PAGE_DATA && bit_cnt == 3'h0 && byte_cnt != 2'h0));
    assign start_status = commit && pending == PEND_STATUS && latch_ok
                        && !hard_protect_mode;
    assign start_page   = commit && pending == PEND_PAGE && latch_ok && !addr_protected;
    assign start_zone   = commit && pending == PEND_ZONE && latch_ok && !addr_protected;
    assign start_array  = commit && pending == PEND_ARRAY && latch_ok
                        && protect_level == 3'h0;
    assign timer_load   = start_status | start_page | start_zone | start_array;

    always_comb
    begin
        timer_value = 32'(STATUS_CYCLES);
        if (start_page)
            timer_value = 32'(PAGE_CYCLES);
        else if (start_zone)
            timer_value = 32'(ZONE_CYCLES);
        else if (start_array)
            timer_value = 32'(ARRAY_CYCLES);
    end

    cycle_timer u_timer (
        .clock      (clock),
        .rst        (rst),
        .load       (timer_load),
        .load_value (timer_value),
        .busy       (busy_flag),
        .done       (timer_done)
    );

    // ----------------------------------------------------------------
    // latch and non-volatile bits
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            write_latch_flag <= 1'b0;
        end
        else if (commit && pending == PEND_UNLOCK)
        begin
            write_latch_flag <= 1'b1;
        end
        else if ((commit && pending == PEND_LOCK) || timer_done)
        begin
            write_latch_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            status_lock_bit <= LOCK_RESET;
            protect_level   <= PROTECT_RESET;
            staged_nv       <= {LOCK_RESET, PROTECT_RESET};
            cycle_is_status <= 1'b0;
        end
        else if (timer_load)
        begin
            cycle_is_status <= start_status;
            staged_nv       <= {status_data[LOCK_BIT], status_data[PROTECT_MSB:PROTECT_LSB]};
        end
        else if (timer_done && cycle_is_status)
        begin
            status_lock_bit <= staged_nv[3];
            protect_level   <= staged_nv[2:0];
        end
    end

    // ----------------------------------------------------------------
    // array operation request
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            array_op_start <= 1'b0;
            array_op_kind  <= OP_NONE;
            array_op_addr  <= 24'h0;
        end
        else
        begin
            array_op_start <= start_page | start_zone | start_array;
            if (start_page | start_zone | start_array)
            begin
                array_op_kind <= start_page ? OP_PAGE : (start_zone ? OP_ZONE : OP_ARRAY);
                array_op_addr <= addr;
            end
        end
    end

    // ----------------------------------------------------------------
    // serial output on falling edges
    // ----------------------------------------------------------------
    logic [4:0]  out_idx;
    logic [23:0] ident_word;

    assign ident_word = {MAKER_CODE, MEMORY_TYPE, MEMORY_SIZE};

    always_ff @(posedge clock)
    begin
        if (rst || !selected)
        begin
            serial_out    <= 1'b0;
            serial_out_oe <= 1'b0;
            out_idx       <= 5'h0;
        end
        else
        begin
            serial_out_oe <= (state == ST_ID_OUT) || (state == ST_STATUS_OUT);
            if (sclk_fall && state == ST_ID_OUT)
            begin
                serial_out <= (out_idx < 5'(IDENT_BITS)) ? ident_word[5'd23 - out_idx] : 1'b0;
                if (out_idx < 5'(IDENT_BITS))
                    out_idx <= out_idx + 5'h1;
            end
            else if (sclk_fall && state == ST_STATUS_OUT)
            begin
                serial_out <= status_byte[3'd7 - out_idx[2:0]];
                out_idx    <= {2'b00, out_idx[2:0] + 3'h1};
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_BUSY_AFTER_STATUS_START: assert property (start_status |=> busy_flag [*3])
        else $error("busy flag not held after status write start");
    AST_LATCH_CLEAR_AT_END: assert property (timer_done |=> !write_latch_flag)
        else $error("write latch not cleared at cycle end");
    AST_LOCKED_REJECTS: assert property (commit && pending == PEND_STATUS
        && hard_protect_mode |=> !busy_flag && $stable(protect_level))
        else $error("status write accepted in hardware protect mode");
    AST_WRITE_NEEDS_LATCH: assert property (timer_load |-> write_latch_flag)
        else $error("timed cycle started without write latch");
    AST_ARRAY_NEEDS_ZERO: assert property (start_array |-> protect_level == 3'h0)
        else $error("whole array clear with protection set");
    AST_NV_HELD_IN_CYCLE: assert property (busy_flag && !timer_done
        |=> $stable(protect_level) && $stable(status_lock_bit))
        else $error("protect bits changed before cycle end");
    AST_IDENT_IGNORED_BUSY: assert property (sclk_rise && state == ST_CMD && bit_cnt == 3'h7
        && next_byte == READ_IDENT_CMD && busy_flag |=> state == ST_IGNORE)
        else $error("identification decoded while busy");
    AST_ZERO_BITS: assert property (status_byte[6:5] == 2'b00)
        else $error("status bits 6 and 5 not zero");
    AST_SELECT_END_STANDBY: assert property (sel_end |=> state == ST_CMD && !serial_out_oe)
        else $error("readout not ended by select rising");
    AST_UNLOCK_SETS: assert property (commit && pending == PEND_UNLOCK |=> write_latch_flag)
        else $error("unlock command did not set latch");

endmodule : serial_flash_status_protect

// ==== rtl/flash_status_pkg.sv ====
// constants and types for the serial flash status and protection block
package flash_status_pkg;

    // ----------------------------------------------------------------
    // command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] WRITE_UNLOCK_CMD       = 8'h06;
    localparam logic [7:0] WRITE_LOCK_CMD         = 8'h04;
    localparam logic [7:0] READ_IDENT_CMD         = 8'h9F;
    localparam logic [7:0] READ_STATUS_CMD        = 8'h05;
    localparam logic [7:0] WRITE_STATUS_CMD       = 8'h01;
    localparam logic [7:0] PAGE_WRITE_CMD         = 8'h02;
    localparam logic [7:0] ZONE_CLEAR_CMD         = 8'hD8;
    localparam logic [7:0] WHOLE_ARRAY_CLEAR_CMD  = 8'hC7;

    // ----------------------------------------------------------------
    // status byte layout
    // ----------------------------------------------------------------
    localparam int         BUSY_BIT        = 0;
    localparam int         LATCH_BIT       = 1;
    localparam int         PROTECT_LSB     = 2;
    localparam int         PROTECT_MSB     = 4;
    localparam int         LOCK_BIT        = 7;
    localparam logic [2:0] PROTECT_RESET   = 3'h0;
    localparam logic       LOCK_RESET      = 1'b0;

    // ----------------------------------------------------------------
    // identification bytes, values arbitrary
    // ----------------------------------------------------------------
    localparam logic [7:0] MAKER_CODE      = 8'hA5;
    localparam logic [7:0] MEMORY_TYPE     = 8'h3C;
    localparam logic [7:0] MEMORY_SIZE     = 8'h5A;
    localparam int         IDENT_BITS      = 24;

    // ----------------------------------------------------------------
    // self-timed cycle lengths
    // ----------------------------------------------------------------
    localparam int CLOCK_MHZ                = 100;
    localparam int STATUS_WRITE_TIME_US     = 5000;
    localparam int PAGE_WRITE_TIME_US       = 1400;
    localparam int ZONE_CLEAR_TIME_US       = 1000000;
    localparam int ARRAY_CLEAR_TIME_US      = 20000000;
    localparam int STATUS_WRITE_CYCLES      = STATUS_WRITE_TIME_US * CLOCK_MHZ;
    localparam int PAGE_WRITE_CYCLES        = PAGE_WRITE_TIME_US * CLOCK_MHZ;
    localparam int ZONE_CLEAR_CYCLES        = ZONE_CLEAR_TIME_US * CLOCK_MHZ;
    localparam int ARRAY_CLEAR_CYCLES       = ARRAY_CLEAR_TIME_US * CLOCK_MHZ;
    localparam int SECTOR_COUNT             = 64;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_CMD, ST_ID_OUT, ST_STATUS_OUT, ST_STATUS_DATA,
        ST_ADDR, ST_PAGE_DATA, ST_WAIT_END, ST_IGNORE
    } link_state_t;

    typedef enum logic [2:0] {
        PEND_NONE, PEND_UNLOCK, PEND_LOCK, PEND_STATUS,
        PEND_PAGE, PEND_ZONE, PEND_ARRAY
    } pending_t;

    typedef enum logic [1:0] {
        OP_NONE, OP_PAGE, OP_ZONE, OP_ARRAY
    } array_op_t;

endpackage : flash_status_pkg

// ==== rtl/pin_sync.sv ====
// two flip-flop synchroniser for pins entering the clock domain
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] stage;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            stage   <= '1;
            pin_out <= '1;
        end
        else
        begin
            stage   <= pin_in;
            pin_out <= stage;
        end
    end
endmodule : pin_sync

// ==== rtl/cycle_timer.sv ====
// down counter for self-timed write and erase cycles
`timescale 1ns/1ps
module cycle_timer (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        load,
    input  wire logic [31:0] load_value,
    output logic             busy,
    output logic             done
);
    logic [31:0] count;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            count <= 32'h0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (load)
            begin
                count <= load_value;
                busy  <= 1'b1;
            end
            else if (busy)
            begin
                if (count <= 32'h1)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                else
                begin
                    count <= count - 32'h1;
                end
            end
        end
    end
endmodule : cycle_timer

// ==== test/spi_master_model.sv ====
// serial link master model that drives the flash block's select, clock and data
`timescale 1ns/1ps
module spi_master_model (
    input  wire logic       clock,
    input  wire logic       serial_out,
    output logic            select_n,
    output logic            serial_clock,
    output logic            serial_in,
    output logic            rx_valid,
    output logic [7:0]      rx_byte
);
    initial
    begin
        select_n     = 1'b1;
        serial_clock = 1'b0;
        serial_in    = 1'b0;
        rx_valid     = 1'b0;
        rx_byte      = 8'h00;
    end

    // ------------------------------------------------------------
    // frame control, all changes just after a falling system edge
    // ------------------------------------------------------------
    task automatic frame_start;
        @(negedge clock);
        select_n = 1'b0;
        repeat (8) @(negedge clock);
    endtask : frame_start

    // select rises two clocks after the call, whether or not the last byte is whole
    task automatic frame_end;
        repeat (2) @(negedge clock);
        select_n  = 1'b1;
        serial_in = ~serial_in;
        repeat (8) @(negedge clock);
    endtask : frame_end

    // one bit, 160 ns link period, data read at the rising link edge
    task automatic xfer_bit(input logic b);
        serial_in = b;
        repeat (8) @(negedge clock);
        serial_clock = 1'b1;
        rx_byte      = {rx_byte[6:0], serial_out};
        repeat (8) @(negedge clock);
        serial_clock = 1'b0;
    endtask : xfer_bit

    // one byte, most significant bit first
    task automatic xfer(input logic [7:0] tx, input logic chk);
        for (int i = 7; i >= 0; i--)
        begin
            xfer_bit(tx[i]);
        end
        rx_valid = chk;
        @(negedge clock);
        rx_valid = 1'b0;
    endtask : xfer
endmodule : spi_master_model

// ==== test/tb_top.sv ====
// self-checking bench for the serial flash status and protection block
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_top;
    import flash_status_pkg::*;
    logic        clock, rst, write_protect_n, select_n, serial_clock, serial_in, serial_out, serial_out_oe;
    logic        busy_flag, write_latch_flag, hard_protect_mode, array_op_start, rx_valid;
    logic [7:0]  status_byte, rx_byte, exp_b, d, exp_s;
    logic [23:0] array_op_addr;
    array_op_t   array_op_kind;
    logic [7:0]  exp_q[$];
    logic [25:0] op_q[$];
    logic [25:0] exp_op;
    logic        miso;
    int          n_fail = 0, n_checks = 0, n_ops = 0, tmp;
    int          seed   = 32'h4b068779;

    serial_flash_status_protect #(.STATUS_CYCLES(1000), .PAGE_CYCLES(30), .ZONE_CYCLES(40), .ARRAY_CYCLES(60)) DUT (
        .clock(clock), .rst(rst), .select_n(select_n), .serial_clock(serial_clock), .serial_in(serial_in),
        .write_protect_n(write_protect_n), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .busy_flag(busy_flag), .write_latch_flag(write_latch_flag), .hard_protect_mode(hard_protect_mode),
        .status_byte(status_byte), .array_op_start(array_op_start), .array_op_kind(array_op_kind),
        .array_op_addr(array_op_addr));
    // released data line shows the inverse, so a read without drive is caught
    assign miso = serial_out_oe ? serial_out : ~serial_out;
    spi_master_model u_m (.clock(clock), .serial_out(miso), .select_n(select_n),
        .serial_clock(serial_clock), .serial_in(serial_in), .rx_valid(rx_valid), .rx_byte(rx_byte));

    always #5 clock = ~clock;

    // ------------------------------------------------------------
    // result monitor: oldest expected byte against each byte read
    // ------------------------------------------------------------
    always @(posedge clock)
    begin
        if (rx_valid === 1'b1)
        begin
            exp_b = exp_q.pop_front();
            `CHK(rx_byte, exp_b)
        end
        if (array_op_start === 1'b1)
        begin
            n_ops++;
            exp_op = op_q.pop_front();
            `CHK({array_op_kind, array_op_addr}, exp_op)
        end
    end

    // ------------------------------------------------------------
    // link tasks
    // ------------------------------------------------------------
    task automatic send(input logic [7:0] op);
        u_m.frame_start();
        u_m.xfer(op, 1'b0);
        u_m.frame_end();
    endtask : send

    task automatic wr_status(input logic [7:0] v);
        u_m.frame_start();
        u_m.xfer(WRITE_STATUS_CMD, 1'b0);
        u_m.xfer(v, 1'b0);
        u_m.frame_end();
    endtask : wr_status

    task automatic rd(input logic [7:0] op, input int n, input logic [23:0] e);
        int r;
        u_m.frame_start();
        u_m.xfer(op, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            exp_q.push_back(e[23-8*i -: 8]);
            r = $random(seed);
            u_m.xfer(r[7:0], 1'b1);
        end
        u_m.frame_end();
    endtask : rd

    task automatic zone(input logic [23:0] a);
        u_m.frame_start();
        u_m.xfer(ZONE_CLEAR_CMD, 1'b0);
        for (int i = 2; i >= 0; i--)
        begin
            u_m.xfer(a[8*i +: 8], 1'b0);
        end
        u_m.frame_end();
    endtask : zone

    task automatic finish_test;
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    // whole sequence takes about 7.6k clocks
    initial
    begin
        #400000;
        n_fail++;
        finish_test();
    end

    initial
    begin
        clock = 1'b0;
        rst = 1'b1;
        write_protect_n = 1'b1;
        repeat (6) @(negedge clock);
        rst = 1'b0;
        repeat (4) @(negedge clock);
        rd(READ_STATUS_CMD, 2, 24'h000000);
        rd(READ_IDENT_CMD, 3, {MAKER_CODE, MEMORY_TYPE, MEMORY_SIZE});
        `CHK(serial_out_oe, 1'b0)
        wr_status(8'h9C);
        repeat (20) @(negedge clock);
        `CHK(busy_flag, 1'b0)
        `CHK(status_byte, 8'h00)
        send(WRITE_UNLOCK_CMD);
        `CHK(write_latch_flag, 1'b1)
        send(WRITE_LOCK_CMD);
        `CHK(write_latch_flag, 1'b0)
        send(WRITE_UNLOCK_CMD);
        tmp = $random(seed);
        d = {1'b1, tmp[6:3], 1'b1, tmp[1:0]};
        exp_s = {1'b1, 2'b00, d[4:2], 2'b00};
        wr_status(d);
        u_m.frame_start();
        u_m.xfer(READ_IDENT_CMD, 1'b0);
        u_m.xfer(8'h00, 1'b0);
        `CHK(serial_out_oe, 1'b0)
        u_m.frame_end();
        rd(READ_STATUS_CMD, 2, {3{8'h03}});
        repeat (1100) @(negedge clock);
        rd(READ_STATUS_CMD, 1, {3{exp_s}});
        `CHK(status_byte, exp_s)
        send(WRITE_UNLOCK_CMD);
        send(WHOLE_ARRAY_CLEAR_CMD);
        repeat (20) @(negedge clock);
        `CHK(busy_flag, 1'b0)
        u_m.frame_start();
        u_m.xfer(WRITE_STATUS_CMD, 1'b0);
        u_m.xfer(8'h00, 1'b0);
        u_m.xfer_bit(1'b0);
        u_m.frame_end();
        `CHK(busy_flag, 1'b0)
        `CHK(status_byte, exp_s | 8'h02)
        write_protect_n = 1'b0;
        repeat (6) @(negedge clock);
        `CHK(hard_protect_mode, 1'b1)
        wr_status(8'h00);
        repeat (20) @(negedge clock);
        `CHK(status_byte, exp_s | 8'h02)
        zone(24'h3F0000);
        `CHK(busy_flag, 1'b0)
        write_protect_n = 1'b1;
        repeat (6) @(negedge clock);
        `CHK(hard_protect_mode, 1'b0)
        wr_status(8'h00);
        repeat (1100) @(negedge clock);
        `CHK(status_byte, 8'h00)
        `CHK(n_ops, 0)
        send(WRITE_UNLOCK_CMD);
        op_q.push_back({OP_ZONE, 24'h123456});
        zone(24'h123456);
        `CHK(busy_flag, 1'b1)
        repeat (60) @(negedge clock);
        `CHK(n_ops, 1)
        `CHK(write_latch_flag, 1'b0)
        finish_test();
    end
endmodule : tb_top
